// File: src/sasi_top.sv
// status and mode indication logic of the serial adapter
// Functional notes
// - config light steady in normal mode, two flashes per second in programming
// - receive light flashes while data arrives from the peripheral
// - transmit light flashes while data goes out to the peripheral
// - full-duplex and half-duplex lights each lit only in their mode
// - echo in half-duplex loops own transmit back and lights echo
// - termination light lit while line termination is switched in
// - slew light lit when limiting on; baud capped 250k, else 3M
// - fail-safe light lit while extra bias pull resistors are engaged
// - power light follows the 5V output good level
// - frame uses 7 or 8 data bits, five parity kinds, 1 or 2 stops
// - flow control is none or rts/cts handshaking, rts/cts only in full-duplex
// - baud from 300 up to 921.6k standard, custom up to 3M
// - exactly one of full-duplex or half-duplex at any time
// - echo allowed only in half-duplex mode
module sasi_top
  import sasi_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // serial lines and power good level seen by the indication logic (pins)
  input  wire logic              rx_line,
  input  wire logic              tx_line,
  input  wire logic              pwr_good,
  // line controls
  output logic                   rx_echo_sel,
  output logic                   term_en,
  output logic                   slew_en,
  output logic                   extra_failsafe_bias,
  output logic                   rtscts_en,
  // indicators
  output logic                   led_config,
  output logic                   led_rx,
  output logic                   led_tx,
  output logic                   led_full,
  output logic                   led_half,
  output logic                   led_echo,
  output logic                   line_termination_indicator,
  output logic                   led_slew,
  output logic                   led_failsafe,
  output logic                   output_power_indicator,
  // interrupt
  output logic                   irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

  always_comb begin
    s1_d = {pwr_good, tx_line, rx_line};
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
    end else if (clk_en) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // lines idle high; a falling edge marks activity
  logic rx_edge, tx_edge, pwr_fall;
  always_comb begin
    rx_edge  = s3_q[0] & ~s2_q[0];
    tx_edge  = s3_q[1] & ~s2_q[1];
    pwr_fall = s3_q[2] & ~s2_q[2];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
  logic [FRAME_W-1:0] frame_q, frame_d;
  logic [BAUD_W-1:0]  baud_q, baud_d;
  logic [IRQ_W-1:0]   ist_q, ist_d, ien_q, ien_d;
  logic [DATA_W-1:0]  rdata_d;
  logic               baud_bad;

  function automatic logic [BAUD_W-1:0] baud_limit(input logic slew);
    baud_limit = slew ? BAUD_W'(BAUD_SLEW_MAX) : BAUD_W'(BAUD_FAST_MAX);
  endfunction

  function automatic logic [BAUD_W-1:0] clamp_baud(input logic [BAUD_W-1:0] b,
                                                    input logic slew);
    if (b < BAUD_W'(BAUD_MIN))
      clamp_baud = BAUD_W'(BAUD_MIN);
    else if (b > baud_limit(slew))
      clamp_baud = baud_limit(slew);
    else
      clamp_baud = b;
  endfunction

  always_comb begin
    ctrl_d   = ctrl_q;
    frame_d  = frame_q;
    baud_d   = baud_q;
    ien_d    = ien_q;
    baud_bad = 1'b0;
    rdata_d  = '0;
    if (wr) begin
      unique case (addr)
        REG_CTRL: begin
          ctrl_d = wdata[CTRL_W-1:0];
          ctrl_d[CB_ECHO] = wdata[CB_ECHO] & wdata[CB_HALF];
        end
        REG_FRAME: begin
          frame_d = wdata[FRAME_W-1:0];
          if (wdata[FB_PAR_LO +: 3] > 3'(SASI_PAR_SPACE))
            frame_d[FB_PAR_LO +: 3] = 3'(SASI_PAR_NONE);
        end
        REG_BAUD: begin
          baud_d = clamp_baud(wdata[BAUD_W-1:0], ctrl_q[CB_SLEW]);
          baud_bad = (baud_d != wdata[BAUD_W-1:0]);
        end
        REG_IRQ_EN: ien_d = wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // slew switched on later also pulls the rate down
    if (baud_d > baud_limit(ctrl_d[CB_SLEW]))
      baud_d = baud_limit(ctrl_d[CB_SLEW]);
    if (rd) begin
      unique case (addr)
        REG_CTRL:     rdata_d = DATA_W'(ctrl_q);
        REG_FRAME:    rdata_d = DATA_W'(frame_q);
        REG_BAUD:     rdata_d = DATA_W'(baud_q);
        REG_STATUS:   rdata_d = {22'h0, output_power_indicator, led_failsafe, led_slew,
                                 line_termination_indicator, led_echo, led_half,
                                 led_full, led_tx, led_rx, led_config};
        REG_IRQ_STAT: rdata_d = DATA_W'(ist_q);
        REG_IRQ_EN:   rdata_d = DATA_W'(ien_q);
        default:      rdata_d = '0;
      endcase
    end
    // set wins over clear
    ist_d = ist_q;
    if (wr && addr == REG_IRQ_CLR)
      ist_d = ist_q & ~wdata[IRQ_W-1:0];
    ist_d[IB_RX]   = ist_d[IB_RX]   | rx_edge;
    ist_d[IB_TX]   = ist_d[IB_TX]   | tx_edge;
    ist_d[IB_PWR]  = ist_d[IB_PWR]  | pwr_fall;
    ist_d[IB_BAUD] = ist_d[IB_BAUD] | baud_bad;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q  <= CTRL_RST[CTRL_W-1:0];
      frame_q <= {1'b0, 3'(SASI_PAR_NONE), 1'b1};
      baud_q  <= BAUD_RST[BAUD_W-1:0];
      ist_q   <= '0;
      ien_q   <= '0;
      rdata   <= '0;
    end else if (clk_en) begin
      ctrl_q  <= ctrl_d;
      frame_q <= frame_d;
      baud_q  <= baud_d;
      ist_q   <= ist_d;
      ien_q   <= ien_d;
      rdata   <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // blink and flash timers
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] blink_q, blink_d, rxs_q, rxs_d, txs_q, txs_d;
  logic             phase_q, phase_d;

  function automatic logic [CNT_W-1:0] stretch(input logic [CNT_W-1:0] c,
                                               input logic ev);
    if (ev)
      stretch = CNT_W'(FLASH_MIN_CYC);
    else if (c != '0)
      stretch = c - CNT_W'(1);
    else
      stretch = '0;
  endfunction

  always_comb begin
    phase_d = phase_q;
    blink_d = blink_q + CNT_W'(1);
    if (blink_q == CNT_W'(BLINK_HALF_CYC - 1)) begin
      blink_d = '0;
      phase_d = ~phase_q;
    end
    rxs_d = stretch(rxs_q, rx_edge);
    txs_d = stretch(txs_q, tx_edge);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      blink_q <= '0;
      phase_q <= 1'b1;
      rxs_q   <= '0;
      txs_q   <= '0;
    end else if (clk_en) begin
      blink_q <= blink_d;
      phase_q <= phase_d;
      rxs_q   <= rxs_d;
      txs_q   <= txs_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      led_config <= 1'b0;
      led_rx <= 1'b0;
      led_tx <= 1'b0;
      led_full <= 1'b0;
      led_half <= 1'b0;
      led_echo <= 1'b0;
      line_termination_indicator <= 1'b0;
      led_slew <= 1'b0;
      led_failsafe <= 1'b0;
      output_power_indicator <= 1'b0;
      rx_echo_sel <= 1'b0;
      term_en <= 1'b0;
      slew_en <= 1'b0;
      extra_failsafe_bias <= 1'b0;
      rtscts_en <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      led_config <= ctrl_q[CB_PROG] ? phase_q : 1'b1;
      led_rx <= (rxs_q != '0);
      led_tx <= (txs_q != '0);
      led_full <= ~ctrl_q[CB_HALF];
      led_half <= ctrl_q[CB_HALF];
      led_echo <= ctrl_q[CB_ECHO] & ctrl_q[CB_HALF];
      rx_echo_sel <= ctrl_q[CB_ECHO] & ctrl_q[CB_HALF];
      term_en <= ctrl_q[CB_TERM];
      line_termination_indicator <= ctrl_q[CB_TERM];
      slew_en <= ctrl_q[CB_SLEW];
      led_slew <= ctrl_q[CB_SLEW];
      extra_failsafe_bias <= ctrl_q[CB_BIAS];
      led_failsafe <= ctrl_q[CB_BIAS];
      output_power_indicator <= s3_q[2];
      rtscts_en <= ctrl_q[CB_RTSCTS] & ~ctrl_q[CB_HALF];
      irq <= |(ist_q & ien_q);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // !rst keeps the attempt at the release edge from seeing reset-cleared lights
  chk_mode_exclusive: assert property (!rst && clk_en |=> led_full != led_half)
    else $error("duplex lights not exclusive");
  chk_echo_half: assert property (led_echo |-> led_half)
    else $error("echo lit outside half-duplex");
  chk_echo_path: assert property (led_echo == rx_echo_sel)
    else $error("echo light and path disagree");
  chk_term_light: assert property (line_termination_indicator == term_en)
    else $error("termination light mismatch");
  chk_slew_cap: assert property (ctrl_q[CB_SLEW] |-> baud_q <= BAUD_W'(BAUD_SLEW_MAX))
    else $error("baud above slew cap");
  chk_baud_range: assert property (baud_q >= BAUD_W'(BAUD_MIN))
    else $error("baud below minimum");
  chk_failsafe_light: assert property (led_failsafe == extra_failsafe_bias)
    else $error("fail-safe light mismatch");
  chk_pwr_follow: assert property (!rst && clk_en |=>
    output_power_indicator == $past(s3_q[2]))
    else $error("power light does not follow");
  chk_rx_stretch: assert property (clk_en && rx_edge ##1 clk_en |=> led_rx)
    else $error("rx flash missing");
  chk_tx_stretch: assert property (clk_en && tx_edge ##1 clk_en |=> led_tx)
    else $error("tx flash missing");
  chk_config_steady: assert property (!rst && clk_en && !ctrl_q[CB_PROG] |=> led_config)
    else $error("config light not steady");
  chk_parity_legal: assert property (frame_q[FB_PAR_LO +: 3] <= 3'(SASI_PAR_SPACE))
    else $error("illegal parity code");

  cov_prog_blink: cover property (ctrl_q[CB_PROG] && $fell(led_config));
  cov_echo_on: cover property ($rose(led_echo));
  cov_irq_fire: cover property ($rose(irq));
  cov_rx_flash: cover property ($fell(led_rx));
endmodule

// File: pkg/sasi_pkg.sv
// constants and types for the serial adapter status indication block
package sasi_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  // blink: two flashes per second, so 250 ms per half period
  localparam int unsigned BLINK_HALF_MS   = 250;
  localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
  // least visible activity flash
  localparam int unsigned FLASH_MIN_MS    = 50;
  localparam int unsigned FLASH_MIN_CYC   = CLK_HZ / 1000 * FLASH_MIN_MS;
  localparam int unsigned CNT_W           = 22;
  // baud limits in bits per second
  localparam int unsigned BAUD_MIN        = 300;
  localparam int unsigned BAUD_STD_MAX    = 921_600;
  localparam int unsigned BAUD_SLEW_MAX   = 250_000;
  localparam int unsigned BAUD_FAST_MAX   = 3_000_000;
  localparam int unsigned BAUD_W          = 22;
  // register port
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 32;
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_FRAME       = 4'h1;
  localparam logic [3:0]  REG_BAUD        = 4'h2;
  localparam logic [3:0]  REG_STATUS      = 4'h3;
  localparam logic [3:0]  REG_IRQ_STAT    = 4'h4;
  localparam logic [3:0]  REG_IRQ_EN      = 4'h5;
  localparam logic [3:0]  REG_IRQ_CLR     = 4'h6;
  // control bits
  localparam int unsigned CB_HALF   = 0;
  localparam int unsigned CB_ECHO   = 1;
  localparam int unsigned CB_TERM   = 2;
  localparam int unsigned CB_SLEW   = 3;
  localparam int unsigned CB_BIAS   = 4;
  localparam int unsigned CB_PROG   = 5;
  localparam int unsigned CB_RTSCTS = 6;
  localparam int unsigned CTRL_W    = 7;
  // frame bits: [0] eight data bits, [3:1] parity, [4] two stop bits
  localparam int unsigned FB_DATA8  = 0;
  localparam int unsigned FB_PAR_LO = 1;
  localparam int unsigned FB_STOP2  = 4;
  localparam int unsigned FRAME_W   = 5;
  // irq bits
  localparam int unsigned IB_RX     = 0;
  localparam int unsigned IB_TX     = 1;
  localparam int unsigned IB_PWR    = 2;
  localparam int unsigned IB_BAUD   = 3;
  localparam int unsigned IRQ_W     = 4;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] BAUD_RST = 32'h0000_2580;
  typedef enum logic [2:0] {
    SASI_PAR_NONE, SASI_PAR_EVEN, SASI_PAR_ODD, SASI_PAR_MARK, SASI_PAR_SPACE
  } sasi_parity_t;
endpackage

// File: verif/sasi_peer.sv
// far-side serial peer model that sends frames on the receive line
module sasi_peer (
  // clock
  input  wire logic       clk,
  // frame request
  input  wire logic       send,
  input  wire logic [7:0] data,
  input  wire logic [7:0] bit_cyc,
  output logic            busy,
  // line, idle high
  output logic            rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] frm;
  assign frm = {1'b1, data, 1'b0};
  initial begin
    busy = 1'b0;
    rx_line = 1'b1;
  end
  // start, eight data bits lsb first, one stop; line left high after
  always @(posedge clk) begin
    if (send === 1'b1) begin
      busy <= 1'b1;
      for (int i = 0; i < 10; i++) begin
        rx_line <= frm[i];
        repeat (bit_cyc) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// File: verif/tb_sasi_top.sv
// self-checking bench for the status indication block
module tb_sasi_top
  import sasi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // signals
  // ------
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              clk_en = 1'b1;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              send = 1'b0;
  logic              tx_line = 1'b1;
  logic              pwr_good = 1'b1;
  logic [7:0]        data = 8'h00;
  logic [7:0]        bit_cyc = 8'h01;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v;
  logic [10:0]       outs;
  logic              rx_line, busy, irq, led_config, led_rx, led_tx, led_full, led_half;
  logic              rx_echo_sel, term_en, slew_en, extra_failsafe_bias, rtscts_en, led_echo;
  logic              line_termination_indicator, led_slew, led_failsafe, output_power_indicator;
  int                seed = 53742;
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                c, e, k;
  int                bw[5] = '{299, 300, 921600, 3000001, 300000};

  sasi_top i_dut (
    .clk, .rst, .clk_en, .addr, .wdata, .wr, .rd, .rdata, .rx_line, .tx_line, .pwr_good,
    .rx_echo_sel, .term_en, .slew_en, .extra_failsafe_bias, .rtscts_en, .led_config,
    .led_rx, .led_tx, .led_full, .led_half, .led_echo, .line_termination_indicator,
    .led_slew, .led_failsafe, .output_power_indicator, .irq
  );
  sasi_peer i_peer (.clk, .send, .data, .bit_cyc, .busy, .rx_line);

  assign outs = {led_full, led_half, led_echo, rx_echo_sel, term_en, line_termination_indicator,
                 slew_en, led_slew, extra_failsafe_bias, led_failsafe, rtscts_en};
  always #50 clk = ~clk;
  // ------
  // tasks
  // ------
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #10 v = rdata;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #10;
  endtask
  // bounded wait: 0 peer idle, 1 tx light on, 2 power light off
  task automatic wait_hi(input int s);
    for (int i = 0; i < 4000; i++) begin
      if ((s == 0 && busy === 1'b0) || (s == 1 && led_tx === 1'b1) ||
          (s == 2 && output_power_indicator === 1'b0)) return;
      @(posedge clk);
      #10;
    end
    n_mismatch++;
    report_and_stop();
  endtask
  task automatic chk_ctrl(input logic [6:0] b);
    logic        h;
    logic [10:0] e1;
    h = b[0];
    e1 = {!h, h, {2{b[1] & h}}, {2{b[2]}}, {2{b[3]}}, {2{b[4]}}, b[6] & !h};
    chk(outs, e1);
    rreg(REG_STATUS);
    chk(v, {22'h0, 1'b1, b[4:2], b[1] & h, h, !h, 3'b001});
  endtask
  // ------
  // sequence
  // ------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(led_config, 1'b1);
    chk_ctrl(7'h00);
    rreg(REG_FRAME);
    chk(v, 32'h0000_0001);
    rreg(REG_BAUD);
    chk(v, 32'h0000_2580);
    for (k = 7; k < 16; k++) begin
      rreg(k[3:0]);
      chk(v, 32'h0000_0000);
    end
    wreg(REG_CTRL, 32'h0000_0002);
    wreg(4'h7, 32'h0000_00FF);
    settle();
    chk_ctrl(7'h00);
    for (k = 0; k < 12; k++) begin
      // programming bit included: the first blink half period from reset is lit
      c = $random(seed) & 32'h0000_007F;
      if (c[0] == 1'b0) c[1] = 1'b0;
      wreg(REG_CTRL, c);
      settle();
      chk_ctrl(c[6:0]);
      rreg(REG_CTRL);
      chk(v, c);
      chk(led_config, 1'b1);
    end
    for (k = 0; k < 8; k++) begin
      c = ($random(seed) & 32'h0000_0011) | (k << 1);
      wreg(REG_FRAME, c);
      rreg(REG_FRAME);
      chk(v, (k > 4) ? (c & 32'h0000_0011) : c);
    end
    for (k = 0; k < 5; k++) begin
      e = (k == 4) ? BAUD_SLEW_MAX : BAUD_FAST_MAX;
      e = (bw[k] < BAUD_MIN) ? BAUD_MIN : (bw[k] > e) ? e : bw[k];
      wreg(REG_CTRL, (k == 4) ? 32'h0000_0008 : 32'h0000_0000);
      wreg(REG_BAUD, bw[k]);
      rreg(REG_BAUD);
      chk(v, e);
      rreg(REG_IRQ_STAT);
      chk(v, (e != bw[k]) ? 32'h0000_0008 : 32'h0000_0000);
      wreg(REG_IRQ_CLR, 32'h0000_000F);
    end
    // a write while frozen must not land
    clk_en <= 1'b0;
    wreg(REG_CTRL, 32'h0000_0004);
    clk_en <= 1'b1;
    rreg(REG_CTRL);
    chk(v, 32'h0000_0008);
    wreg(REG_CTRL, 32'h0000_0000);
    wreg(REG_IRQ_EN, 32'h0000_0007);
    for (k = 0; k < 2; k++) begin
      c = $random(seed);
      @(posedge clk);
      data <= c[7:0];
      bit_cyc <= (k == 1) ? 8'h10 : 8'h01;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      #10;
      wait_hi(0);
      chk(led_rx, 1'b1);
      chk(irq, 1'b1);
      rreg(REG_IRQ_STAT);
      chk(v, 32'h0000_0001);
      wreg(REG_IRQ_CLR, 32'h0000_0001);
      settle();
      chk(irq, 1'b0);
    end
    @(posedge clk);
    tx_line <= 1'b0;
    wait_hi(1);
    @(posedge clk);
    tx_line <= 1'b1;
    repeat (1000) @(posedge clk);
    #10;
    chk(led_tx, 1'b1);
    @(posedge clk);
    pwr_good <= 1'b0;
    wait_hi(2);
    rreg(REG_IRQ_STAT);
    chk(v, 32'h0000_0006);
    chk(irq, 1'b1);
    wreg(REG_IRQ_EN, 32'h0000_0000);
    settle();
    chk(irq, 1'b0);
    wreg(REG_IRQ_CLR, 32'h0000_000F);
    wreg(REG_IRQ_EN, 32'h0000_0007);
    settle();
    chk(irq, 1'b0);
    rreg(REG_STATUS);
    chk(v[9], 1'b0);
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
